/* File: sdds_consts.svh */
// constants for the decimal divide and square root sequencer
// assumes 24-digit BCD words, least significant digit in the low nibble
`ifndef SDDS_CONSTS_SVH
`define SDDS_CONSTS_SVH

`define SDDS_DIGITS 24
`define SDDS_WORD_W 96
`define SDDS_POS_W 5
`define SDDS_POS_ZERO 5'h00
`define SDDS_POS_TOP 5'h17
`define SDDS_POS_WRAP2 5'h16
`define SDDS_SQRT_EVEN_PRESET 5'h16
`define SDDS_SQRT_ODD_PRESET 5'h17
`define SDDS_TALLY_ZERO 4'h0
`define SDDS_TALLY_ONE 4'h1
`define SDDS_WORD_ZERO 96'h0
`define SDDS_DIGIT_ZERO 4'h0
`define SDDS_DIGIT_NINE 4'h9
`define SDDS_DIGIT_TEN 5'h0A
`define SDDS_BCD_ADJ 5'h06

`endif

/* File: sdds_pkg.sv */
// types shared by the sequencer and its datapath helpers
// assumes nothing beyond a systemverilog compiler
package sdds_pkg;

    typedef enum logic [2:0] {
        idle_phase,
        initial_setup_phase,
        alignment_test_phase,
        alignment_shift_phase,
        subtract_phase,
        restore_phase,
        quotient_store_phase,
        pass_phase
    } sdds_phase_type;

    typedef enum logic {
        divide_mode,
        sqrt_mode
    } sdds_mode_type;

endpackage : sdds_pkg

/* File: sdds_word_adder.sv */
// ripple BCD adder over a whole 24-digit word
// assumes both addends hold valid BCD digits
`timescale 1ns/1ps
`include "sdds_consts.svh"

module sdds_word_adder
    import sdds_pkg::*;
(
    input wire logic [`SDDS_WORD_W-1:0] addend_a,
    input wire logic [`SDDS_WORD_W-1:0] addend_b,
    input wire logic carry_in,
    output logic [`SDDS_WORD_W-1:0] sum,
    output logic carry_out
);

    logic [`SDDS_DIGITS:0] carry;

    assign carry[0] = carry_in;
    assign carry_out = carry[`SDDS_DIGITS];

    // one decimal digit per stage; slow but matches word-at-a-time stepping
    genvar i;
    generate
        for (i = 0; i < `SDDS_DIGITS; i = i + 1) begin : g_digit
            logic [4:0] raw;
            logic over;
            logic [4:0] adj;
            assign raw = {1'b0, addend_a[4*i +: 4]} +
                         {1'b0, addend_b[4*i +: 4]} + {4'h0, carry[i]};
            assign over = (raw >= `SDDS_DIGIT_TEN);
            assign adj = over ? (raw + `SDDS_BCD_ADJ) : raw;
            assign sum[4*i +: 4] = adj[3:0];
            assign carry[i+1] = over;
        end
    endgenerate

endmodule : sdds_word_adder

/* File: sdds_msd_finder.sv */
// finds the highest nonzero digit of a BCD word
// assumes a 24-digit word; index is zero when the word is zero
`timescale 1ns/1ps
`include "sdds_consts.svh"

module sdds_msd_finder
    import sdds_pkg::*;
(
    input wire logic [`SDDS_WORD_W-1:0] word,
    output logic [`SDDS_POS_W-1:0] msd_index,
    output logic nonzero
);

    // later digits overwrite earlier ones, so the highest wins
    always_comb begin
        msd_index = `SDDS_POS_ZERO;
        nonzero = 1'b0;
        for (int i = 0; i < `SDDS_DIGITS; i++) begin
            if (word[4*i +: 4] != `SDDS_DIGIT_ZERO) begin
                msd_index = 5'(i);
                nonzero = 1'b1;
            end
        end
    end

endmodule : sdds_msd_finder

/* File: sdds_sequencer.sv */
// phase sequencer for decimal division and square root digit search
// assumes start requests come from logic on ref_clk, one cycle wide,
// and the units position switch is asynchronous; one clock = one word cycle
//
// Contract
// [RULE_01] setup: position to units, clear quotient
// [RULE_02] test divisor order against dividend order
// [RULE_03] shift: position plus one, divisor left
// [RULE_04] test success goes straight to subtraction
// [RULE_05] subtract divisor; tally counts positive results
// [RULE_06] zero position in subtraction sets termination
// [RULE_07] negative result: add back once, then store
// [RULE_08] store tally, position minus one, shift, clear
// [RULE_09] return to subtraction via an idle pass
// [RULE_10] after termination set, one more restore/store
// [RULE_11] position counter wraps modulo twenty-four
// [RULE_12] end at position 23 with termination set
// [RULE_13] root digits found highest first by search
// [RULE_14] subtract 2a plus odd increment series
// [RULE_15] square term low digit on even power
// [RULE_16] increment placed twice the 2a shift
// [RULE_17] fractional digits shift remainder for alignment
// [RULE_18] root digit counts positive subtractions, restore overshoot
// [RULE_19] search runs until lowest digit developed
// [RULE_20] sqrt preset 22 even units, 23 odd
// [RULE_21] sqrt ends at 23 with termination set
// [RULE_22] on end go idle and clear termination
`timescale 1ns/1ps
`include "sdds_consts.svh"

module sdds_sequencer
    import sdds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic start_divide,
    input wire logic start_sqrt,
    input wire logic [`SDDS_POS_W-1:0] units_position,
    input wire logic [`SDDS_WORD_W-1:0] operand_a,
    input wire logic [`SDDS_WORD_W-1:0] operand_b,
    output logic busy,
    output logic done,
    output sdds_phase_type phase,
    output logic [`SDDS_POS_W-1:0] position,
    output logic [3:0] tally,
    output logic terminate,
    output logic [`SDDS_DIGITS-1:0] selected_digit_strobe,
    output logic [`SDDS_WORD_W-1:0] quotient,
    output logic [`SDDS_WORD_W-1:0] remainder
);

    sdds_phase_type phase_q, phase_d;
    sdds_mode_type mode_q, mode_d;
    logic [`SDDS_POS_W-1:0] pos_q, pos_d;
    logic [3:0] tally_q, tally_d;
    logic term_q, term_d;
    logic lo_q, lo_d;
    logic busy_q, busy_d;
    logic done_q, done_d;
    logic [`SDDS_WORD_W-1:0] rem_q, rem_d;
    logic [`SDDS_WORD_W-1:0] div_q, div_d;
    logic [`SDDS_WORD_W-1:0] entry_q, entry_d;
    logic [`SDDS_WORD_W-1:0] quot_q, quot_d;
    logic [`SDDS_DIGITS-1:0] strobe_q, strobe_d;
    logic [`SDDS_POS_W-1:0] units_meta_q;
    logic [`SDDS_POS_W-1:0] units_sync_q;

    // switch input crosses in through two flops
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            units_meta_q <= `SDDS_POS_ZERO;
            units_sync_q <= `SDDS_POS_ZERO;
        end else begin
            units_meta_q <= units_position;
            units_sync_q <= units_meta_q;
        end
    end

    // modulo-24 neighbours of the position count
    logic [`SDDS_POS_W-1:0] pos_inc;
    logic [`SDDS_POS_W-1:0] pos_dec1;
    logic [`SDDS_POS_W-1:0] pos_dec2;
    logic pos_is_zero;
    logic pos_is_top;
    logic pos_is_units;
    assign pos_is_zero = (pos_q == `SDDS_POS_ZERO);
    assign pos_is_top = (pos_q == `SDDS_POS_TOP);
    assign pos_is_units = (pos_q == units_sync_q);
    assign pos_inc = pos_is_top ? `SDDS_POS_ZERO : pos_q + 5'h01; // RULE_11
    assign pos_dec1 = pos_is_zero ? `SDDS_POS_TOP : pos_q - 5'h01; // RULE_11
    assign pos_dec2 = (pos_q < 5'h02) ? pos_q + `SDDS_POS_WRAP2
                                      : pos_q - 5'h02;

    // odd increment 2*tally+1 as two BCD digits, 1..19
    logic [4:0] inc_bin;
    logic inc_tens;
    logic [4:0] inc_low;
    logic [3:0] inc_units;
    assign inc_bin = {tally_q, 1'b1}; // RULE_14
    assign inc_tens = (inc_bin >= `SDDS_DIGIT_TEN);
    assign inc_low = inc_tens ? inc_bin - `SDDS_DIGIT_TEN : inc_bin;
    assign inc_units = inc_low[3:0];

    // word-wide digit placement driven by the position count
    logic [`SDDS_WORD_W-1:0] inc_word;
    logic [`SDDS_WORD_W-1:0] nines_word;
    logic [`SDDS_WORD_W-1:0] q_store_word;
    logic [`SDDS_WORD_W-1:0] q_insert_word;
    logic [`SDDS_WORD_W-1:0] q_rshift;
    logic [`SDDS_WORD_W-1:0] term_word;
    logic [`SDDS_WORD_W-1:0] sqrt_term;
    assign q_rshift = {`SDDS_DIGIT_ZERO, quot_q[`SDDS_WORD_W-1:4]};

    genvar i;
    generate
        for (i = 0; i < `SDDS_DIGITS; i = i + 1) begin : g_place
            logic at_pos;
            logic at_next;
            logic at_prev;
            assign at_pos = (pos_q == 5'(i));
            assign at_next = (pos_inc == 5'(i)) && !pos_is_top;
            assign at_prev = (pos_dec1 == 5'(i));
            // low digit of the increment sits on the selected slot,
            // tens digit one slot higher
            assign inc_word[4*i +: 4] = at_pos ? inc_units :
                at_next ? {3'h0, inc_tens} : `SDDS_DIGIT_ZERO; // RULE_15
            assign nines_word[4*i +: 4] =
                `SDDS_DIGIT_NINE - term_word[4*i +: 4];
            assign q_store_word[4*i +: 4] =
                at_pos ? tally_q : quot_q[4*i +: 4]; // RULE_08
            assign q_insert_word[4*i +: 4] =
                at_prev ? tally_q : q_rshift[4*i +: 4];
            assign strobe_d[i] = (pos_d == 5'(i));
        end
    endgenerate

    // sqrt term is 2a plus the placed increment
    sdds_word_adder u_term_adder (
        .addend_a(entry_q),
        .addend_b(inc_word),
        .carry_in(1'b0),
        .sum(sqrt_term),
        .carry_out()
    ); // RULE_16

    assign term_word = (mode_q == sqrt_mode) ? sqrt_term : div_q;

    // doubling the partial root forms the next 2a
    logic [`SDDS_WORD_W-1:0] double_quot;
    sdds_word_adder u_double_adder (
        .addend_a(quot_q),
        .addend_b(quot_q),
        .carry_in(1'b0),
        .sum(double_quot),
        .carry_out()
    );

    // one adder serves subtraction (ten's complement) and restore
    logic sub_sel;
    logic [`SDDS_WORD_W-1:0] addsub_b;
    logic [`SDDS_WORD_W-1:0] addsub_sum;
    logic no_borrow;
    assign sub_sel = (phase_q == subtract_phase);
    assign addsub_b = sub_sel ? nines_word : term_word;
    sdds_word_adder u_main_adder (
        .addend_a(rem_q),
        .addend_b(addsub_b),
        .carry_in(sub_sel),
        .sum(addsub_sum),
        .carry_out(no_borrow)
    );

    // order test for alignment
    logic [`SDDS_POS_W-1:0] rem_msd;
    logic [`SDDS_POS_W-1:0] div_msd;
    logic div_nonzero;
    logic aligned;
    sdds_msd_finder u_rem_msd (
        .word(rem_q),
        .msd_index(rem_msd),
        .nonzero()
    );
    sdds_msd_finder u_div_msd (
        .word(div_q),
        .msd_index(div_msd),
        .nonzero(div_nonzero)
    );
    // zero divisor or a divisor already at the top stops the shifting,
    // otherwise the shift loop would never end
    assign aligned = (div_msd >= rem_msd) || !div_nonzero ||
                     (div_msd == `SDDS_POS_TOP); // RULE_02

    logic end_now;
    assign end_now = term_q && pos_is_top; // RULE_12 RULE_21

    // phase stepping, one word cycle per step
    always_comb begin
        phase_d = phase_q;
        mode_d = mode_q;
        pos_d = pos_q;
        tally_d = tally_q;
        term_d = term_q;
        lo_d = lo_q;
        busy_d = busy_q;
        done_d = 1'b0;
        rem_d = rem_q;
        div_d = div_q;
        entry_d = entry_q;
        quot_d = quot_q;
        case (phase_q)
            idle_phase: begin
                if (start_divide) begin
                    mode_d = divide_mode;
                    phase_d = initial_setup_phase;
                    busy_d = 1'b1;
                    rem_d = operand_a;
                    div_d = operand_b;
                end else if (start_sqrt) begin
                    mode_d = sqrt_mode;
                    phase_d = initial_setup_phase;
                    busy_d = 1'b1;
                    rem_d = operand_a;
                    div_d = `SDDS_WORD_ZERO;
                end
            end
            initial_setup_phase: begin
                if (mode_q == divide_mode) begin
                    pos_d = units_sync_q; // RULE_01
                end else if (units_sync_q[0]) begin
                    pos_d = `SDDS_SQRT_ODD_PRESET; // RULE_20
                end else begin
                    pos_d = `SDDS_SQRT_EVEN_PRESET; // RULE_20
                end
                quot_d = `SDDS_WORD_ZERO; // RULE_01
                entry_d = `SDDS_WORD_ZERO;
                tally_d = `SDDS_TALLY_ZERO;
                term_d = 1'b0;
                lo_d = 1'b0;
                phase_d = alignment_test_phase;
            end
            alignment_test_phase: begin
                if (mode_q == sqrt_mode) begin
                    phase_d = pass_phase;
                end else if (aligned) begin
                    phase_d = subtract_phase; // RULE_04
                end else begin
                    phase_d = alignment_shift_phase; // RULE_02
                end
            end
            alignment_shift_phase: begin
                pos_d = pos_inc; // RULE_03
                div_d = {div_q[`SDDS_WORD_W-5:0], `SDDS_DIGIT_ZERO}; // RULE_03
                phase_d = alignment_test_phase; // RULE_03
            end
            subtract_phase: begin
                if (end_now) begin
                    phase_d = idle_phase; // RULE_22
                    term_d = 1'b0; // RULE_22
                    busy_d = 1'b0;
                    done_d = 1'b1;
                end else begin
                    // the difference is kept even when negative;
                    // restore undoes it
                    rem_d = addsub_sum; // RULE_05 RULE_14 RULE_13
                    term_d = term_q | pos_is_zero; // RULE_06
                    if (no_borrow) begin
                        tally_d = tally_q + `SDDS_TALLY_ONE; // RULE_05 RULE_18
                    end else begin
                        phase_d = restore_phase; // RULE_07
                    end
                end
            end
            restore_phase: begin
                rem_d = addsub_sum; // RULE_07 RULE_18
                if (mode_q == sqrt_mode) begin
                    lo_d = lo_q | pos_is_units;
                end
                phase_d = quotient_store_phase; // RULE_07 RULE_10
            end
            quotient_store_phase: begin
                tally_d = `SDDS_TALLY_ZERO; // RULE_08
                phase_d = pass_phase; // RULE_09
                if ((mode_q == divide_mode) || lo_q) begin
                    quot_d = q_store_word; // RULE_08 RULE_10
                    pos_d = pos_dec1; // RULE_08 RULE_11
                    // remainder moves left instead of 2a moving right
                    rem_d = {rem_q[`SDDS_WORD_W-5:0],
                             `SDDS_DIGIT_ZERO}; // RULE_08 RULE_17
                end else begin
                    quot_d = q_insert_word; // RULE_13
                    pos_d = pos_dec2; // RULE_16
                end
            end
            pass_phase: begin
                if (mode_q == sqrt_mode) begin
                    entry_d = double_quot; // RULE_14
                end
                phase_d = subtract_phase; // RULE_09 RULE_19
            end
            default: begin
                phase_d = idle_phase;
            end
        endcase
    end

    // sequencing state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_q <= idle_phase;
            mode_q <= divide_mode;
            pos_q <= `SDDS_POS_ZERO;
            tally_q <= `SDDS_TALLY_ZERO;
        end else begin
            phase_q <= phase_d;
            mode_q <= mode_d;
            pos_q <= pos_d;
            tally_q <= tally_d;
        end
    end

    // flags and status
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            term_q <= 1'b0;
            lo_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            strobe_q <= 24'h000001;
        end else begin
            term_q <= term_d;
            lo_q <= lo_d;
            busy_q <= busy_d;
            done_q <= done_d;
            strobe_q <= strobe_d;
        end
    end

    // operand words
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rem_q <= `SDDS_WORD_ZERO;
            div_q <= `SDDS_WORD_ZERO;
            entry_q <= `SDDS_WORD_ZERO;
            quot_q <= `SDDS_WORD_ZERO;
        end else begin
            rem_q <= rem_d;
            div_q <= div_d;
            entry_q <= entry_d;
            quot_q <= quot_d;
        end
    end

    // every output is a flop
    assign busy = busy_q;
    assign done = done_q;
    assign phase = phase_q;
    assign position = pos_q;
    assign tally = tally_q;
    assign terminate = term_q;
    assign selected_digit_strobe = strobe_q;
    assign quotient = quot_q;
    assign remainder = rem_q;

endmodule : sdds_sequencer

/* File: sdds_seq_chk_sva.sv */
// concurrent checks on the sequencer's phase, counters and flags
// assumes it is bound to sdds_sequencer; one clock, async reset rst
`timescale 1ns/1ps
`include "sdds_consts.svh"

module sdds_seq_chk
    import sdds_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic busy,
    input wire logic done,
    input wire sdds_phase_type phase,
    input wire logic [`SDDS_POS_W-1:0] position,
    input wire logic [3:0] tally,
    input wire logic terminate,
    input wire logic [`SDDS_DIGITS-1:0] selected_digit_strobe,
    input wire logic [`SDDS_WORD_W-1:0] quotient
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // phase walk and the counters tied to each phase
    chk_setup_next: assert property (
        phase == initial_setup_phase |=>
        phase == alignment_test_phase && quotient == `SDDS_WORD_ZERO)
        else $error("setup did not clear quotient before test");
    chk_test_exit: assert property (
        phase == alignment_test_phase |=>
        phase inside {alignment_shift_phase, subtract_phase, pass_phase})
        else $error("alignment test left to a wrong phase");
    chk_shift_step: assert property (
        phase == alignment_shift_phase |=> phase == alignment_test_phase
        && position == (($past(position) == `SDDS_POS_TOP) ?
        `SDDS_POS_ZERO : $past(position) + 5'h01))
        else $error("shift did not add one and return to test");
    chk_tally_step: assert property (
        phase == subtract_phase ##1 phase == subtract_phase |->
        tally == $past(tally) + 4'h1)
        else $error("tally did not count a positive subtraction");
    chk_term_set: assert property (
        phase == subtract_phase && position == `SDDS_POS_ZERO |=> terminate)
        else $error("termination flag not set at position zero");
    chk_restore_once: assert property (
        phase == restore_phase |=> phase == quotient_store_phase)
        else $error("restore did not go straight to storage");
    chk_store_pass: assert property (
        phase == quotient_store_phase |=> tally == `SDDS_TALLY_ZERO
        && phase == pass_phase ##1 phase == subtract_phase)
        else $error("storage did not clear tally and pass to subtract");
    chk_store_wrap: assert property (
        phase == quotient_store_phase && position == `SDDS_POS_ZERO
        |=> position == `SDDS_POS_TOP)
        else $error("position did not wrap from zero to top");
    chk_end_idle: assert property (
        phase == subtract_phase && position == `SDDS_POS_TOP && terminate
        |=> phase == idle_phase && !terminate && done && !busy)
        else $error("routine did not end at top position with flag");
    chk_done_once: assert property (
        done |=> !done)
        else $error("done held longer than one cycle");
    chk_strobe_pos: assert property (
        selected_digit_strobe == (24'h000001 << position))
        else $error("digit strobe does not match position");
endmodule : sdds_seq_chk

bind sdds_sequencer sdds_seq_chk chk_u (
    .ref_clk(ref_clk),
    .rst(rst),
    .busy(busy),
    .done(done),
    .phase(phase),
    .position(position),
    .tally(tally),
    .terminate(terminate),
    .selected_digit_strobe(selected_digit_strobe),
    .quotient(quotient)
);

/* File: sdds_ctrl_model.sv */
// function control model: units switch and one-cycle start requests
// assumes the caller waits for done before the next normal request
`timescale 1ns/1ps
`include "sdds_consts.svh"

module sdds_ctrl_model
    import sdds_pkg::*;
(
    input wire logic ref_clk,
    output logic start_divide,
    output logic start_sqrt,
    output logic [`SDDS_POS_W-1:0] units_position,
    output logic [`SDDS_WORD_W-1:0] operand_a,
    output logic [`SDDS_WORD_W-1:0] operand_b
);
    // operands carry junk outside a request, nothing may rely on them
    initial begin
        start_divide = 1'b0;
        start_sqrt = 1'b0;
        units_position = 5'h00;
        operand_a = {24{4'hA}};
        operand_b = {24{4'hF}};
    end

    // switch moves, then settles past the two-flop synchroniser
    task set_units(input logic [`SDDS_POS_W-1:0] u);
        @(posedge ref_clk);
        #1;
        units_position = u;
        repeat (4) @(posedge ref_clk);
    endtask : set_units

    // one-cycle request; operands go stale right after it is taken
    task request(input sdds_mode_type m, input logic [95:0] a,
        input logic [95:0] b);
        @(posedge ref_clk);
        #1;
        start_divide = (m == divide_mode);
        start_sqrt = (m == sqrt_mode);
        operand_a = a;
        operand_b = b;
        @(posedge ref_clk);
        #1;
        start_divide = 1'b0;
        start_sqrt = 1'b0;
        operand_a = ~a;
        operand_b = ~b;
    endtask : request
endmodule : sdds_ctrl_model

/* File: serial_decimal_divide_sqrt_sequencer_tb_top.sv */
// self-checking bench: divide and root requests with known results
// assumes the control model drives all request inputs of the sequencer
`timescale 1ns/1ps
`include "sdds_consts.svh"

module serial_decimal_divide_sqrt_sequencer_tb_top
    import sdds_pkg::*;
;
    logic ref_clk, rst, start_divide, start_sqrt, busy, done, terminate;
    logic [`SDDS_POS_W-1:0] units_position, position;
    logic [`SDDS_WORD_W-1:0] operand_a, operand_b, quotient, remainder;
    logic [3:0] tally;
    logic [`SDDS_DIGITS-1:0] selected_digit_strobe;
    sdds_phase_type phase;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycle_cnt = 0;

    sdds_sequencer dut_u (.ref_clk(ref_clk), .rst(rst),
        .start_divide(start_divide), .start_sqrt(start_sqrt),
        .units_position(units_position), .operand_a(operand_a),
        .operand_b(operand_b), .busy(busy), .done(done), .phase(phase),
        .position(position), .tally(tally), .terminate(terminate),
        .selected_digit_strobe(selected_digit_strobe),
        .quotient(quotient), .remainder(remainder));

    sdds_ctrl_model ctl_u (.ref_clk(ref_clk), .start_divide(start_divide),
        .start_sqrt(start_sqrt), .units_position(units_position),
        .operand_a(operand_a), .operand_b(operand_b));

    // 25 MHz
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task stop_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // hang guard, far beyond the few hundred cycles the cases need
    always @(posedge ref_clk) begin
        cycle_cnt++;
        if (cycle_cnt == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    task check(input string what, input logic [95:0] seen,
        input logic [95:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one routine: optional refused start mid-run, then final state
    task run_case(input sdds_mode_type m, input logic [95:0] a,
        input logic [95:0] b, input logic [4:0] u, input logic refuse,
        input logic [95:0] exp_q, input logic [95:0] exp_r,
        input logic [4:0] exp_pt);
        logic [4:0] pt;
        logic seen_test;
        int k;
        pt = 5'h1F;
        seen_test = 1'b0;
        ctl_u.set_units(u);
        ctl_u.request(m, a, b);
        if (refuse) ctl_u.request(sqrt_mode, 96'h9, 96'h0);
        for (k = 0; k < 1000 && done !== 1'b1; k++) begin
            @(posedge ref_clk);
            #2;
            if (phase === alignment_test_phase && !seen_test) begin
                pt = position;
                seen_test = 1'b1;
            end
        end
        check("done", {95'h0, done}, 96'h1);
        check("busy", {95'h0, busy}, 96'h0);
        check("terminate", {95'h0, terminate}, 96'h0);
        check("phase", {93'h0, phase}, {93'h0, idle_phase});
        check("position", {91'h0, position}, 96'h17);
        check("quotient", quotient, exp_q);
        check("remainder", remainder, exp_r);
        if (!refuse) begin
            check("preset", {91'h0, pt}, {91'h0, exp_pt});
        end
    endtask : run_case

    initial begin
        rst = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        // plain, aligned after one shift, nonzero remainder, units moved
        run_case(divide_mode, 96'h6, 96'h3, 5'h00, 1'b0, 96'h2, 96'h0, 5'h00);
        run_case(divide_mode, 96'h84, 96'h4, 5'h00, 1'b0, 96'h21, 96'h0,
            5'h00);
        run_case(divide_mode, 96'h7, 96'h2, 5'h00, 1'b0, 96'h3, 96'h10, 5'h00);
        run_case(divide_mode, 96'h6, 96'h3, 5'h02, 1'b0, 96'h200, 96'h0,
            5'h02);
        // a root start while busy must be ignored
        run_case(divide_mode, 96'h6, 96'h3, 5'h00, 1'b1, 96'h2, 96'h0, 5'h00);
        // even and odd units slot presets
        run_case(sqrt_mode, 96'h4, 96'h0, 5'h00, 1'b0, 96'h2, 96'h0, 5'h16);
        run_case(sqrt_mode, 96'h40, 96'h0, 5'h01, 1'b0, 96'h20, 96'h0, 5'h17);
        // two root digits: second search subtracts a nonzero 2a term
        run_case(sqrt_mode, 96'h144, 96'h0, 5'h00, 1'b0, 96'h12, 96'h0, 5'h16);
        // reset in mid-run drops back to idle
        ctl_u.request(divide_mode, 96'h84, 96'h4);
        repeat (3) @(posedge ref_clk);
        #1;
        rst = 1'b1;
        @(posedge ref_clk);
        #1;
        rst = 1'b0;
        check("reset phase", {93'h0, phase}, {93'h0, idle_phase});
        check("reset busy", {95'h0, busy}, 96'h0);
        run_case(divide_mode, 96'h84, 96'h4, 5'h00, 1'b0, 96'h21, 96'h0,
            5'h00);
        stop_test();
    end
endmodule : serial_decimal_divide_sqrt_sequencer_tb_top
